// ### rtl/spiee_pkg.sv
// shared constants and types of the serial eeprom command core
package spiee_pkg;

  // instruction codes, msb first on the wire
  localparam logic [7:0] OP_READ      = 8'h03;  // array read
  localparam logic [7:0] OP_WRITE     = 8'h02;  // array write
  localparam logic [7:0] OP_SET_LATCH = 8'h06;  // set_latch_cmd
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;  // clear_latch_cmd
  localparam logic [7:0] OP_STAT_RD   = 8'h05;  // status_read_cmd
  localparam logic [7:0] OP_STAT_WR   = 8'h01;  // status_write_cmd
  localparam logic [7:0] OP_PG_ERASE  = 8'h42;  // page_erase_cmd
  localparam logic [7:0] OP_SEC_ERASE = 8'hD8;  // sector_erase_cmd
  localparam logic [7:0] OP_CHP_ERASE = 8'hC7;  // whole array erase
  localparam logic [7:0] OP_WAKE      = 8'hAB;  // wake_signature_cmd
  localparam logic [7:0] OP_SLEEP     = 8'hB9;  // deep_sleep_cmd

  // array geometry
  localparam int          ADDR_W       = 16;
  localparam int          PAGE_BYTES   = 128;
  localparam int          SECTOR_BYTES = 16384;
  localparam logic [15:0] PROT_QUARTER = 16'hC000;  // start of upper quarter
  localparam logic [15:0] PROT_HALF    = 16'h8000;  // start of upper half
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

  // signature byte, value is arbitrary
  localparam logic [7:0]  SIG_DEFAULT  = 8'h5A;

  // nonvolatile status reset values
  localparam logic        PEN_RESET    = 1'b0;
  localparam logic [1:0]  BP_RESET     = 2'h0;

  // timing: longest times round down to whole cycles
  localparam int CLK_FREQ_HZ   = 10000000;
  localparam int WRITE_TIME_US = 5000;   // byte, page and page erase
  localparam int ERASE_TIME_US = 10000;  // sector and chip erase
  localparam int WRITE_CYC     = (WRITE_TIME_US * (CLK_FREQ_HZ / 1000)) / 1000;
  localparam int ERASE_CYC     = (ERASE_TIME_US * (CLK_FREQ_HZ / 1000)) / 1000;

  // status byte layout
  typedef struct packed {
    logic       protect_pin_enable;  // bit 7
    logic [2:0] unused;              // bits 6..4, read zero
    logic       block_protect_high;  // bit 3
    logic       block_protect_low;   // bit 2
    logic       latch_status_bit;    // bit 1
    logic       busy_bit;            // bit 0
  } spiee_status_type;

  // pin samples that travel through the synchroniser together
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } spiee_pins_type;

  // serial command states
  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,  // collecting opcode
    ST_ADDR  = 3'b001,  // collecting two address bytes
    ST_WDATA = 3'b010,  // collecting write data
    ST_OUT   = 3'b011,  // shifting data out
    ST_SWR   = 3'b100,  // collecting status write byte
    ST_DONE  = 3'b101,  // waiting for chip select to rise
    ST_IGN   = 3'b110   // ignoring until deselect
  } spiee_state_type;

endpackage

// ### rtl/spiee_core.sv
// command interpreter of a 64 KiB serial eeprom on an spi-style link
//
// Summary of operation
// - opcode held in eight-bit instruction register
// - input sampled on rising clock after select
// - all fields shifted msb first
// - pause resumes at the same bit
// - 03 reads, 02 writes from address
// - 06,04 latch; 05,01 status read/write
// - 42 page, d8 sector, c7 chip erase
// - ab wakes with signature, b9 sleeps
// - read: opcode, 16-bit address, then data
// - read pointer increments, wraps, until deselect
// - latch sets only at deselect after opcode
// - partial page rewrites untouched bytes too
// - write offset wraps inside the page
// - write starts only on whole-byte deselect
// - busy refuses array reads and status writes, allows status read
// - latch cleared at reset and after writes
// - status layout: pen, 000, bp, latch, busy
// - busy bit high during internal write
// - latch commands work regardless of protection
// - block protect only by status write
// - protect codes: none, quarter, half, all
// - pin protection blocks status writes only
// - internal write finishes within 5 ms
// - array commands ignored while busy
module spiee_core
  import spiee_pkg::*;
#(
  parameter int         MEM_BYTES = 65536,
  parameter int         PAGE      = PAGE_BYTES,
  parameter int         SECTOR    = SECTOR_BYTES,
  parameter int         WR_CYC    = WRITE_CYC,
  parameter int         ER_CYC    = ERASE_CYC,
  parameter logic [7:0] SIG       = SIG_DEFAULT
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic cs_n_pin,
  input  wire logic sck_pin,
  input  wire logic si_pin,
  input  wire logic hold_n_pin,
  input  wire logic wp_n_pin,
  output logic      so_out,
  output logic      so_oe
);

  localparam int PW = $clog2(PAGE);    // page offset width
  localparam int SW = $clog2(SECTOR);  // sector offset width
  localparam int TW = $clog2(ER_CYC + 1);

  // refuse shapes the walk and address logic cannot serve
  if (MEM_BYTES != (1 << ADDR_W) || PAGE != (1 << PW) || SECTOR != (1 << SW) ||
      SECTOR < PAGE || WR_CYC < PAGE + 1 || ER_CYC < MEM_BYTES + 1 ||
      ER_CYC < WR_CYC) begin : g_bad_params
    $error("spiee_core: unsupported parameter values");
  end

  // pin synchroniser, first stage read only by the second
  spiee_pins_type pins_meta_r;  // first stage
  spiee_pins_type pins_sync_r;  // second stage
  spiee_pins_type pins_prev_r;  // edge history

  // serial side state
  spiee_state_type  state_r;      // command state
  spiee_state_type  dec_nxt;      // state after opcode
  logic [7:0]       op_r;         // instruction register
  logic [7:0]       sh_r;         // input shifter
  logic [2:0]       bit_r;        // bit within byte
  logic             abyte_r;      // second address byte
  logic [15:0]      addr_r;       // address and read pointer
  logic             got_r;        // at least one data byte
  logic [7:0]       out_sh_r;     // output shifter
  logic [2:0]       outcnt_r;     // output bit count
  logic [7:0]       next_byte;    // byte to shift out next
  logic [7:0]       stat_wd_r;    // status write data
  logic             sleep_r;      // deep power-down

  // status and engine state
  logic             latch_r;      // write enable latch
  logic             pen_r;        // protect_pin_enable
  logic [1:0]       bp_r;         // block protect bits
  logic             busy_r;       // internal cycle running
  logic [TW-1:0]    tmr_r;        // cycle timer
  logic [TW-1:0]    lim_r;        // timer limit
  logic [16:0]      walk_r;       // bytes done
  logic [16:0]      len_r;        // bytes to do
  logic [15:0]      base_r;       // first byte address
  logic             erase_r;      // fill with erased value

  // page buffer and array
  logic [7:0]       buf_r [PAGE];       // page buffer
  logic [PAGE-1:0]  mask_r;             // loaded offsets
  logic [7:0]       mem_r [MEM_BYTES];  // the array
  logic             mem_we;
  logic [15:0]      mem_wa;
  logic [7:0]       mem_wd;
  logic [PW-1:0]    wofs;               // walk offset in page

  spiee_status_type status;

  // level and edge terms, all from synchronised samples
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic       cs_fall;
  logic       byte_done;
  logic [7:0] byte_in;
  logic       hw_prot;

  // start events, all taken at deselect
  logic go_setl;
  logic go_clrl;
  logic go_swr;
  logic go_write;
  logic go_perase;
  logic go_serase;
  logic go_cerase;
  logic go_sleep;
  logic go_any;

  // protected range per block protect code
  function automatic logic is_prot(input logic [1:0] bp, input logic [15:0] a);
    unique case (bp)
      2'h0: is_prot = 1'b0;
      2'h1: is_prot = (a >= PROT_QUARTER);
      2'h2: is_prot = (a >= PROT_HALF);
      2'h3: is_prot = 1'b1;
    endcase
  endfunction

  // two-stage pin synchroniser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pins_meta_r <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      pins_sync_r <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      pins_prev_r <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
    end else if (clk_en) begin
      pins_meta_r <= '{cs_n: cs_n_pin, sck: sck_pin, si: si_pin,
                       hold_n: hold_n_pin, wp_n: wp_n_pin};
      pins_sync_r <= pins_meta_r;
      pins_prev_r <= pins_sync_r;
    end
  end

  // clock edges count only while selected and not paused
  always_comb begin
    sck_rise  = pins_sync_r.sck & ~pins_prev_r.sck & ~pins_sync_r.cs_n &
                pins_sync_r.hold_n;
    sck_fall  = ~pins_sync_r.sck & pins_prev_r.sck & ~pins_sync_r.cs_n &
                pins_sync_r.hold_n;
    cs_rise   = pins_sync_r.cs_n & ~pins_prev_r.cs_n;
    cs_fall   = ~pins_sync_r.cs_n & pins_prev_r.cs_n;
    byte_in   = {sh_r[6:0], pins_sync_r.si};
    byte_done = sck_rise && (bit_r == 3'h7);
    hw_prot   = ~pins_sync_r.wp_n & pen_r;
  end

  // opcode decode; busy or asleep narrows what is accepted
  always_comb begin
    dec_nxt = ST_IGN;
    if (!sleep_r || byte_in == OP_WAKE) begin
      unique case (byte_in)
        OP_READ, OP_WRITE, OP_PG_ERASE, OP_SEC_ERASE:
          dec_nxt = busy_r ? ST_IGN : ST_ADDR;
        OP_CHP_ERASE, OP_SET_LATCH, OP_CLR_LATCH, OP_SLEEP:
          dec_nxt = busy_r ? ST_IGN : ST_DONE;
        OP_STAT_RD:
          dec_nxt = ST_OUT;
        OP_STAT_WR:
          dec_nxt = busy_r ? ST_IGN : ST_SWR;
        OP_WAKE:
          dec_nxt = ST_ADDR;
        default:
          dec_nxt = ST_IGN;
      endcase
    end
  end

  // live status byte
  always_comb begin
    status = '{protect_pin_enable: pen_r, unused: 3'h0,
               block_protect_high: bp_r[1], block_protect_low: bp_r[0],
               latch_status_bit: latch_r, busy_bit: busy_r};
  end

  // next byte to shift out, by opcode
  always_comb begin
    unique case (op_r)
      OP_READ:    next_byte = mem_r[addr_r];
      OP_STAT_RD: next_byte = status;
      default:    next_byte = SIG;
    endcase
  end

  // deselect commits; a partial byte aborts every one of them
  always_comb begin
    go_setl   = cs_rise && state_r == ST_DONE && bit_r == 3'h0 &&
                op_r == OP_SET_LATCH;
    go_clrl   = cs_rise && state_r == ST_DONE && bit_r == 3'h0 &&
                op_r == OP_CLR_LATCH;
    go_sleep  = cs_rise && state_r == ST_DONE && bit_r == 3'h0 && op_r == OP_SLEEP;
    go_swr    = cs_rise && state_r == ST_DONE && bit_r == 3'h0 &&
                op_r == OP_STAT_WR && latch_r && !hw_prot;
    go_write  = cs_rise && state_r == ST_WDATA && bit_r == 3'h0 && got_r &&
                latch_r && !is_prot(bp_r, addr_r);
    go_perase = cs_rise && state_r == ST_DONE && bit_r == 3'h0 &&
                op_r == OP_PG_ERASE && latch_r && !is_prot(bp_r, addr_r);
    go_serase = cs_rise && state_r == ST_DONE && bit_r == 3'h0 &&
                op_r == OP_SEC_ERASE && latch_r &&
                !is_prot(bp_r, {addr_r[15:SW], SW'(0)});
    go_cerase = cs_rise && state_r == ST_DONE && bit_r == 3'h0 &&
                op_r == OP_CHP_ERASE && latch_r && bp_r == 2'h0;
    go_any    = go_write | go_perase | go_serase | go_cerase;
  end

  // serial command machine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r   <= ST_IGN;
      op_r      <= 8'h00;
      sh_r      <= 8'h00;
      bit_r     <= 3'h0;
      abyte_r   <= 1'b0;
      addr_r    <= 16'h0000;
      got_r     <= 1'b0;
      out_sh_r  <= 8'h00;
      outcnt_r  <= 3'h0;
      stat_wd_r <= 8'h00;
    end else if (clk_en) begin
      if (cs_rise) begin
        state_r <= ST_IGN;
      end else if (cs_fall) begin
        // new selection starts clean
        state_r  <= ST_CMD;
        bit_r    <= 3'h0;
        abyte_r  <= 1'b0;
        got_r    <= 1'b0;
        outcnt_r <= 3'h0;
      end else if (sck_rise) begin
        bit_r <= bit_r + 3'h1;
        sh_r  <= byte_in;
        unique case (state_r)
          ST_CMD: begin
            if (byte_done) begin
              op_r    <= byte_in;
              state_r <= dec_nxt;
            end
          end
          ST_ADDR: begin
            addr_r <= {addr_r[14:0], pins_sync_r.si};
            if (byte_done) begin
              abyte_r <= ~abyte_r;
              if (abyte_r) begin
                // second address byte ends here
                if (op_r == OP_READ || op_r == OP_WAKE) begin
                  state_r <= ST_OUT;
                end else if (op_r == OP_WRITE) begin
                  state_r <= ST_WDATA;
                end else begin
                  state_r <= ST_DONE;
                end
              end
            end
          end
          ST_WDATA: begin
            if (byte_done) begin
              // offset wraps inside the page, page bits stay
              addr_r <= {addr_r[15:PW], addr_r[PW-1:0] + PW'(1)};
              got_r  <= 1'b1;
            end
          end
          ST_SWR: begin
            if (byte_done) begin
              stat_wd_r <= byte_in;
              state_r   <= ST_DONE;
            end
          end
          ST_DONE: begin
            // any bit past the command voids it at deselect
            state_r <= ST_IGN;
          end
          default: begin
            // output and ignore states only count bits
          end
        endcase
      end else if (sck_fall && state_r == ST_OUT) begin
        outcnt_r <= outcnt_r + 3'h1;
        if (outcnt_r == 3'h0) begin
          out_sh_r <= {next_byte[6:0], 1'b0};
          if (op_r == OP_READ) begin
            addr_r <= addr_r + 16'h0001;
          end
        end else begin
          out_sh_r <= {out_sh_r[6:0], 1'b0};
        end
      end
    end
  end

  // deep power-down flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sleep_r <= 1'b0;
    end else if (clk_en) begin
      if (go_sleep) begin
        sleep_r <= 1'b1;
      end else if (sck_rise && byte_done && state_r == ST_CMD && byte_in == OP_WAKE) begin
        sleep_r <= 1'b0;
      end
    end
  end

  // serial output, changed on falling clock edges
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    end else if (clk_en) begin
      // released while paused, deselected or not sending
      so_oe <= ~pins_sync_r.cs_n & pins_sync_r.hold_n & (state_r == ST_OUT);
      if (sck_fall && state_r == ST_OUT) begin
        so_out <= (outcnt_r == 3'h0) ? next_byte[7] : out_sh_r[7];
      end
    end
  end

  // write enable latch; set wins only if nothing clears it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_r <= 1'b0;
    end else if (clk_en) begin
      if (go_clrl || go_swr || go_any) begin
        latch_r <= 1'b0;
      end else if (go_setl) begin
        latch_r <= 1'b1;
      end
    end
  end

  // nonvolatile status bits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pen_r <= PEN_RESET;
      bp_r  <= BP_RESET;
    end else if (clk_en && go_swr) begin
      pen_r <= stat_wd_r[7];
      bp_r  <= stat_wd_r[3:2];
    end
  end

  // page buffer; left alone while busy so the walk sees it intact
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_r <= '0;
    end else if (clk_en) begin
      if (cs_fall && !busy_r) begin
        mask_r <= '0;
      end else if (state_r == ST_WDATA && byte_done) begin
        mask_r[addr_r[PW-1:0]] <= 1'b1;
      end
    end
  end

  // page buffer data, no reset needed behind the mask
  always_ff @(posedge clock) begin
    if (clk_en && state_r == ST_WDATA && byte_done) begin
      buf_r[addr_r[PW-1:0]] <= byte_in;
    end
  end

  // internal cycle engine: walks the range, then waits out the timer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_r  <= 1'b0;
      tmr_r   <= '0;
      lim_r   <= '0;
      walk_r  <= 17'h00000;
      len_r   <= 17'h00000;
      base_r  <= 16'h0000;
      erase_r <= 1'b0;
    end else if (clk_en) begin
      if (go_any) begin
        busy_r  <= 1'b1;
        tmr_r   <= '0;
        walk_r  <= 17'h00000;
        erase_r <= ~go_write;
        lim_r   <= (go_write || go_perase) ? TW'(WR_CYC) : TW'(ER_CYC);
        if (go_cerase) begin
          base_r <= 16'h0000;
          len_r  <= 17'(MEM_BYTES);
        end else if (go_serase) begin
          base_r <= {addr_r[15:SW], SW'(0)};
          len_r  <= 17'(SECTOR);
        end else begin
          base_r <= {addr_r[15:PW], PW'(0)};
          len_r  <= 17'(PAGE);
        end
      end else if (busy_r) begin
        tmr_r <= tmr_r + TW'(1);
        if (mem_we) begin
          walk_r <= walk_r + 17'h00001;
        end
        // the walk always ends at least one cycle before the timer
        if (tmr_r == lim_r - TW'(1)) begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  // array write port; untouched bytes get their old value back
  always_comb begin
    wofs   = walk_r[PW-1:0];
    mem_we = busy_r && (walk_r < len_r);
    mem_wa = base_r + walk_r[15:0];
    if (erase_r) begin
      mem_wd = ERASED_BYTE;
    end else if (mask_r[wofs]) begin
      mem_wd = buf_r[wofs];
    end else begin
      mem_wd = mem_r[mem_wa];
    end
  end

  // the array itself, nonvolatile so never reset
  always_ff @(posedge clock) begin
    if (clk_en && mem_we) begin
      mem_r[mem_wa] <= mem_wd;
    end
  end

endmodule

// ### verification/spiee_core_properties.sv
// pin level checks for the serial eeprom core
module spiee_core_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic hold_n_pin,
  input wire logic wp_n_pin,
  input wire logic so_out,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        sck_q;     // sck one sample back
  logic [15:0] rise_cnt;  // live sck rises in this selection

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !clk_en);  // a frozen core is not checked

  // count rises the device should act on; paused ones do not count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_q    <= 1'b0;
      rise_cnt <= 16'h0000;
    end else begin
      sck_q <= sck_pin;
      if (cs_n_pin) begin
        rise_cnt <= 16'h0000;  // new frame starts from zero
      end else if (hold_n_pin && sck_pin && !sck_q) begin
        rise_cnt <= rise_cnt + 16'h0001;
      end
    end
  end

  deselect_off_a: assert property ($rose(cs_n_pin) |-> ##[1:5] !so_oe)
    else $error("so enable high after deselect");
  idle_quiet_a: assert property (cs_n_pin[*6] |-> !so_oe && $stable(so_out))
    else $error("so active while deselected");
  pause_off_a: assert property (!hold_n_pin[*5] |-> !so_oe)
    else $error("so enable high in pause");
  pause_hold_a: assert property (!hold_n_pin[*6] |=> $stable(so_out))
    else $error("so moved in pause");
  shift_fall_a: assert property (so_oe && $past(so_oe) && $changed(so_out) |->
    !$past(sck_pin, 2)) else $error("so changed outside low clock phase");
  oe_rise_a: assert property ($rose(so_oe) && $past(hold_n_pin, 8) |->
    $past(sck_pin, 3)) else $error("so enable rose away from a clock rise");
  byte_align_a: assert property ($rose(so_oe) && $past(hold_n_pin, 8) |->
    rise_cnt >= 16'h0008 && rise_cnt[2:0] == 3'h0) else $error("output off byte boundary");
  reset_quiet_a: assert property ($past(rst) |-> !so_oe && !so_out)
    else $error("so active right after reset");
endmodule

bind spiee_core spiee_core_checker u_chk (
  .clock, .rst, .clk_en, .cs_n_pin, .sck_pin, .si_pin, .hold_n_pin, .wp_n_pin, .so_out, .so_oe
);

// ### verification/spiee_host.sv
// host controller model driving the core's serial pins
module spiee_host (
  input  wire logic clock,
  input  wire logic so_out,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic oe_seen;  // device drove so in this frame

  // idle link: deselected, clock parked low
  initial begin
    cs_n    = 1'b1;
    sck     = 1'b0;
    si      = 1'b1;
    hold_n  = 1'b1;
    oe_seen = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // each command gets a selection of its own
  task automatic sel();
    @(posedge clock);
    cs_n    <= 1'b0;
    oe_seen = 1'b0;
    tick(4);
  endtask

  // released data line flips so a stale bit never looks driven
  task automatic desel();
    tick(4);
    cs_n <= 1'b1;
    si   <= ~si;
    tick(8);
  endtask

  // one byte msb first, pause before bit hb, only nb bits sent
  task automatic xfer(input logic [7:0] tx, input int hb, input int nb,
                      output logic [7:0] rx);
    for (int i = 7; i > 7 - nb; i--) begin
      si <= tx[i];
      if (i == hb) begin
        hold_n <= 1'b0;
        tick(4);
        sck <= 1'b1;  // clock keeps running while paused
        tick(4);
        sck <= 1'b0;
        tick(4);
        hold_n <= 1'b1;
      end
      tick(4);
      sck <= 1'b1;
      tick(2);
      rx[i]   = so_oe ? so_out : ~so_out;  // released line reads inverted, never passes
      oe_seen = oe_seen | so_oe;
      tick(2);
      sck <= 1'b0;
    end
  endtask
endmodule

// ### verification/spiee_core_tb.sv
// self-checking bench for the serial eeprom command core
module spiee_core_tb
  import spiee_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         WR    = 600;    // short internal write
  localparam logic [7:0] SIG_T = 8'h3C;  // arbitrary signature value
  logic       clock = 1'b0;
  logic       rst   = 1'b1;
  logic       wp_n  = 1'b1;
  logic       cs_n, sck, si, hold_n, so_out, so_oe;
  int         err_count = 0;
  int         cmp_count = 0;
  int         cyc       = 0;
  logic [7:0] rxq[$];  // bytes seen in the last frame

  always #50 clock = ~clock;

  spiee_core #(.WR_CYC(WR), .ER_CYC(70000), .SIG(SIG_T)) u_dut (
    .clock, .rst, .clk_en(1'b1), .cs_n_pin(cs_n), .sck_pin(sck),
    .si_pin(si), .hold_n_pin(hold_n), .wp_n_pin(wp_n), .so_out, .so_oe
  );
  spiee_host u_host (.clock, .so_out, .so_oe, .cs_n, .sck, .si, .hold_n);

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far above the expected run
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one selection; hb is a bit number over the frame, nb cuts the last byte
  task automatic run(input logic [7:0] q[$], input int hb = -1, input int nb = 8);
    logic [7:0] rx;
    rxq = {};
    u_host.sel();
    foreach (q[i]) begin
      u_host.xfer(q[i], (i == hb / 8) ? hb % 8 : -1, (i == q.size() - 1) ? nb : 8, rx);
      rxq.push_back(rx);
    end
    u_host.desel();
  endtask

  task automatic st(input logic [7:0] exp);
    run({OP_STAT_RD, 8'h00});
    check(rxq[1], exp);
  endtask

  // poll busy with a bound
  task automatic settle();
    for (int k = 0; k < 20; k++) begin
      run({OP_STAT_RD, 8'h00});
      if (rxq[1][0] === 1'b0) break;
    end
    check(rxq[1] & 8'h01, 8'h00);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    st(8'h00);
    run({OP_SET_LATCH});
    st(8'h02);
    run({OP_CLR_LATCH});
    st(8'h00);
    $display("test latch done");
    run({OP_SET_LATCH});
    run({OP_PG_ERASE, 8'h00, 8'h10});
    settle();
    run({OP_SET_LATCH});
    run({OP_WRITE, 8'h00, 8'h7E, 8'hA1, 8'hB2, 8'hC3});
    run({OP_READ, 8'h00, 8'h7E, 8'h00});
    check({7'h00, u_host.oe_seen}, 8'h00);
    st(8'h01);
    settle();
    st(8'h00);
    run({OP_READ, 8'h00, 8'h7E, 8'h00, 8'h00}, 19);
    check(rxq[3], 8'hA1);
    check(rxq[4], 8'hB2);
    run({OP_READ, 8'h00, 8'h00, 8'h00, 8'h00});
    check(rxq[3], 8'hC3);
    check(rxq[4], 8'hFF);
    $display("test page write done");
    run({OP_SET_LATCH});
    run({OP_WRITE, 8'hFF, 8'hFF, 8'h5D});
    settle();
    run({OP_READ, 8'hFF, 8'hFF, 8'h00, 8'h00});
    check(rxq[3], 8'h5D);
    check(rxq[4], 8'hC3);
    run({OP_SET_LATCH});
    run({OP_WRITE, 8'h00, 8'h00, 8'h11}, -1, 4);
    st(8'h02);
    run({OP_CLR_LATCH});
    run({OP_SET_LATCH, OP_WRITE, 8'h00, 8'h00, 8'h11});
    st(8'h00);
    $display("test rollover and abort done");
    run({OP_SET_LATCH});
    run({OP_STAT_WR, 8'h8C});
    st(8'h8C);
    run({OP_SET_LATCH});
    run({OP_SEC_ERASE, 8'h00, 8'h00});
    run({OP_CHP_ERASE});
    st(8'h8E);
    wp_n <= 1'b0;
    run({OP_STAT_WR, 8'h00});
    st(8'h8E);
    run({OP_CLR_LATCH});
    st(8'h8C);
    wp_n <= 1'b1;
    run({OP_SET_LATCH});
    run({OP_STAT_WR, 8'h04});
    run({OP_SET_LATCH});
    run({OP_WRITE, 8'hC0, 8'h00, 8'h66});
    st(8'h06);
    run({OP_WRITE, 8'hBF, 8'hFF, 8'h77});
    st(8'h05);
    settle();
    run({OP_SET_LATCH});
    run({OP_STAT_WR, 8'h00});
    $display("test protection done");
    run({8'hFF, 8'h00, 8'h00, 8'h00});
    check({7'h00, u_host.oe_seen}, 8'h00);
    run({OP_SLEEP});
    run({OP_STAT_RD, 8'h00});
    check({7'h00, u_host.oe_seen}, 8'h00);
    run({OP_WAKE, 8'h00, 8'h00, 8'h00});
    check(rxq[3], SIG_T);
    st(8'h00);
    $display("test opcode decode done");
    end_of_test();
  end
endmodule
